/* bench/rtco_osc_model.sv */
// behavioural oscillator driving the timebase input
// assumes the mode outputs of rtco_top steer it
`timescale 1ns/10ps
module rtco_osc_model (
  input  wire logic clk,
  input  wire logic power,
  input  wire logic xtal,
  input  wire logic bias,
  input  wire logic stall,
  output logic      tb_out
);
  logic [3:0] cnt = 4'h0;
  wire  [3:0] half = xtal ? 4'h6 : (bias ? 4'h4 : 4'h8);
  // ----
  // toggle every half period while powered and not stalled
  // ----
  always @(posedge clk)
    if (!power)
    begin
      cnt    <= 4'h0;
      tb_out <= 1'b0;
    end
    else if (stall)
      cnt <= 4'h0;
    else if (cnt >= half - 4'h1)
    begin
      cnt    <= 4'h0;
      tb_out <= !tb_out;
    end
    else
      cnt <= cnt + 4'h1;
endmodule

/* bench/rtco_sva.sv */
// checker on the rtco_top ports
// assumes it is bound into every rtco_top instance
`timescale 1ns/10ps
module rtco_sva #(
  parameter int STUCK_CYC = 20
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       addr_wr,
  input wire logic [3:0] addr_wdata,
  input wire logic       data_wr,
  input wire logic       data_rd,
  input wire logic [7:0] data_wdata,
  input wire logic       timebase_in,
  input wire logic [3:0] internal_address_field,
  input wire logic [7:0] indirect_data_port,
  input wire logic       osc_power_enable,
  input wire logic       crystal_mode_select,
  input wire logic       amplitude_control_enable,
  input wire logic       bias_double_enable,
  input wire logic       rtc_timebase_clock,
  input wire logic       stuck_clock_event
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  wire [3:0] ia  = internal_address_field;
  wire       acc = (data_wr || data_rd) && !addr_wr;
  wire       seq = ia < 4'h6 || (ia > 4'h7 && ia < 4'he);
  wire       rd7 = data_rd && !data_wr && !addr_wr && ia == 4'h7;
  wire [2:0] osc = {amplitude_control_enable, crystal_mode_select,
                    bias_double_enable};
  logic       tb_q;
  logic [7:0] still;
  // ----
  // cycles since the raw timebase last moved
  // ----
  always_ff @(posedge clk)
    tb_q <= timebase_in;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      still <= 8'h00;
    else if (timebase_in != tb_q)
      still <= 8'h00;
    else if (still != 8'hff)
      still <= still + 8'h01;
  a_addr_load:
    assert property (addr_wr && !data_wr && !data_rd |=>
      ia == $past(addr_wdata)) else $error("address not loaded");
  a_addr_step:
    assert property (acc && seq |=> ia == $past(ia) + 4'h1)
      else $error("address not stepped");
  a_power_lag:
    assert property (data_wr && !addr_wr && ia == 4'h6 |-> ##2
      osc_power_enable == $past(data_wdata[7], 2)) else $error("power");
  a_osc_bits:
    assert property (data_wr && !addr_wr && ia == 4'h7 |-> ##2
      osc == $past(data_wdata[7:5], 2)) else $error("osc outputs");
  a_osc_read:
    assert property (rd7 |=> indirect_data_port[7:5] == osc &&
      indirect_data_port[3:1] == 3'h0) else $error("osc readback");
  a_gate_off:
    assert property (!osc_power_enable [*3] |-> !rtc_timebase_clock)
      else $error("timebase not gated");
  a_stuck_once:
    assert property (stuck_clock_event |=> !stuck_clock_event)
      else $error("stuck pulse too long");
  a_stuck_wait:
    assert property (stuck_clock_event |-> still >= 8'(STUCK_CYC - 4))
      else $error("stuck reported early");
  c_stuck: cover property (stuck_clock_event);
  c_wrap: cover property (acc && ia == 4'hd);
  c_osc: cover property (rd7);
endmodule
bind rtco_top rtco_sva #(.STUCK_CYC(STUCK_CYC)) chk (.*);

/* bench/rtco_tb_top.sv */
// self-checking bench for rtco_top
// assumes rtco_sva binds itself and rtco_osc_model feeds the timebase
`timescale 1ns/10ps
module rtco_tb_top;
  logic       clk, rstn, addr_wr, data_wr, data_rd, stall, timebase_in;
  logic       backup_supply_in, osc_power_enable, crystal_mode_select;
  logic       amplitude_control_enable, bias_double_enable;
  logic       rtc_timebase_clock, stuck_clock_event, alarm_event;
  logic [3:0] addr_wdata, internal_address_field;
  logic [7:0] data_wdata, indirect_data_port, v;
  int         mismatches, comparisons, n, i;
  rtco_top #(.STUCK_CYC(20), .VALID_CYC(2)) uut (.*);
  rtco_osc_model osc (.clk(clk), .power(osc_power_enable),
    .xtal(crystal_mode_select), .bias(bias_double_enable),
    .stall(stall), .tb_out(timebase_in));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----
  // access tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sa(input logic [3:0] a);
    @(posedge clk) addr_wr <= 1'b1;
    addr_wdata <= a;
    @(posedge clk) addr_wr <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk) data_wr <= 1'b1;
    data_wdata <= d;
    @(posedge clk) data_wr <= 1'b0;
  endtask
  task automatic rd(output logic [7:0] d);
    @(posedge clk) data_rd <= 1'b1;
    @(posedge clk) data_rd <= 1'b0;
    @(posedge clk) #1 d = indirect_data_port;
  endtask
  task automatic wc(input logic [3:0] a, input logic [7:0] d);
    sa(a);
    wr(d);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] r;
    sa(a);
    rd(r);
    chk(r, e);
  endtask
  task automatic watch(output int h);
    h = 0;
    repeat (40)
    begin
      @(posedge clk) #1;
      if (stuck_clock_event === 1'b1)
        h++;
    end
  endtask
  task automatic rises(output int r);
    logic last;
    r = 0;
    repeat (20) @(posedge clk);
    #1 last = rtc_timebase_clock;
    repeat (48)
    begin
      @(posedge clk) #1;
      if (rtc_timebase_clock && !last)
        r++;
      last = rtc_timebase_clock;
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // test sequence
  // ----
  initial
  begin
    rstn = 1'b0;
    {addr_wr, data_wr, data_rd, stall, backup_supply_in} = 5'h00;
    addr_wdata = 4'h0;
    data_wdata = 8'h00;
    mismatches = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rc(4'h6, 8'h00);
    rc(4'h7, 8'h00);
    rc(4'h0, 8'hff);
    chk(8'(internal_address_field), 8'h01);
    rc(4'hd, 8'hff);
    chk(8'(internal_address_field), 8'h0e);
    sa(4'h8);
    for (i = 1; i < 7; i++)
      wr(8'(i));
    sa(4'h8);
    for (i = 1; i < 7; i++)
    begin
      rd(v);
      chk(v, 8'(i));
    end
    wc(4'h6, 8'h02);
    chk(8'(alarm_event), 8'h00);
    wc(4'h6, 8'h08);
    repeat (4) @(posedge clk);
    chk(8'(alarm_event), 8'h01);
    rc(4'h6, 8'h0c);
    sa(4'h0);
    for (i = 0; i < 6; i++)
      wr(8'h00);
    wc(4'h6, 8'h02);
    wc(4'h6, 8'h00);
    rc(4'h6, 8'h00);
    wc(4'h7, 8'hff);
    rc(4'h7, 8'he0);
    wc(4'h7, 8'h60);
    wc(4'h6, 8'h80);
    sa(4'h7);
    n = 0;
    do
    begin
      rd(v);
      n++;
    end
    while (v[4] !== 1'b1 && n < 40);
    chk(v, 8'h70);
    wc(4'h7, 8'h40);
    rc(4'h7, 8'h50);
    rises(n);
    chk(8'(n), 8'h04);
    @(posedge clk) stall <= 1'b1;
    watch(n);
    chk(8'(n), 8'h00);
    @(posedge clk) stall <= 1'b0;
    wc(4'h6, 8'hc0);
    @(posedge clk) stall <= 1'b1;
    watch(n);
    chk(8'(n), 8'h01);
    rc(4'h6, 8'he0);
    @(posedge clk) stall <= 1'b0;
    wc(4'h6, 8'h00);
    rc(4'h7, 8'h40);
    wc(4'h7, 8'h20);
    wc(4'h6, 8'h80);
    rc(4'h7, 8'h30);
    rises(n);
    chk(8'(n), 8'h06);
    // run the timer for 40 cycles, five timebase periods
    wc(4'h6, 8'h90);
    repeat (38) @(posedge clk);
    wr(8'h81);
    sa(4'h0);
    for (i = 0; i < 6; i++)
    begin
      rd(v);
      chk(v, (i == 0) ? 8'h0a : 8'h00);
    end
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule

/* rtl/rtco_consts.svh */
// constants for the timebase oscillator control block
// assumes inclusion by rtl/rtco_top.sv only, not by rtl/rtco_pkg.sv
`ifndef RTCO_CONSTS_SVH
`define RTCO_CONSTS_SVH

// ---------------------------------------------------------------
// internal addresses
// ---------------------------------------------------------------
`define RTCO_ADDR_SNAP_FIRST 4'h0
`define RTCO_ADDR_SNAP_LAST  4'h5
`define RTCO_ADDR_CTRL       4'h6
`define RTCO_ADDR_OSC        4'h7
`define RTCO_ADDR_ALARM_FLAG_FIRST 4'h8
`define RTCO_ADDR_ALARM_FLAG_LAST  4'hd
`define RTCO_ADDR_RAM_INDEX  4'he
`define RTCO_ADDR_RAM_DATA   4'hf

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define RTCO_CTL_POWER 7
`define RTCO_CTL_DET   6
`define RTCO_CTL_FAIL  5
`define RTCO_CTL_RUN   4
`define RTCO_CTL_AEN   3
`define RTCO_CTL_ALARM_FLAG  2
`define RTCO_CTL_LOAD  1
`define RTCO_CTL_SNAP  0

// ---------------------------------------------------------------
// oscillator control fields
// ---------------------------------------------------------------
`define RTCO_OSC_AMP   7
`define RTCO_OSC_XTAL  6
`define RTCO_OSC_BIAS  5
`define RTCO_OSC_VALID 4
`define RTCO_OSC_BACK  0
`define RTCO_OSC_WMASK 8'he0

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define RTCO_CTRL_RESET  8'h00
`define RTCO_OSC_RESET   8'h00
`define RTCO_BYTE_RESET  8'hff
`define RTCO_CLK_MHZ     250
`define RTCO_STUCK_NS    50000
`define RTCO_STUCK_CYC   ((`RTCO_STUCK_NS * `RTCO_CLK_MHZ) / 1000)
`define RTCO_VALID_CYC   64

`endif

/* rtl/rtco_pkg.sv */
// types of the timebase oscillator control block
// assumes the constants header is on the include path
package rtco_pkg;
  typedef enum logic [2:0] {
    RTCO_ACC_IDLE  = 3'b001,
    RTCO_ACC_WRITE = 3'b010,
    RTCO_ACC_READ  = 3'b100
  } rtco_acc_t;
  typedef logic [46:0] rtco_count_t;
endpackage

/* rtl/rtco_top.sv */
// timebase oscillator control, timer, alarm and stuck-clock detector
// assumes a host driving the indirect address and data ports on clk
//
// Overview of operation
// - timer logic counts only timebase clock edges
// - mode bit selects crystal or self-oscillate
// - bias double picks 20 or 40 kHz
// - self-oscillate mode runs with no wait
// - oscillator bit 7 enables amplitude control
// - oscillator bit 5 doubles bias current
// - control bit 6 enables stuck-clock detector
// - timebase stuck over 50 us sets fail
// - stuck timeout sets fail and pulses stuck_clock_event if enabled
// - timebase usable as system clock and pin
// - address increments after snapshot or alarm access
// - control reached only indirectly at address 0x06
// - internal addresses decode to the register map; 0x0e and 0x0f read 0x00 and ignore writes
// - running timer increments once per timebase cycle
// - timer at or above alarm sets flag
`timescale 1ns/10ps
`include "rtco_consts.svh"

module rtco_top #(
  parameter int STUCK_CYC = `RTCO_STUCK_CYC,
  parameter int VALID_CYC = `RTCO_VALID_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       addr_wr,
  input  wire logic [3:0] addr_wdata,
  input  wire logic       data_wr,
  input  wire logic       data_rd,
  input  wire logic [7:0] data_wdata,
  input  wire logic       timebase_in,
  input  wire logic       backup_supply_in,
  output logic      [3:0] internal_address_field,
  output logic      [7:0] indirect_data_port,
  output logic            osc_power_enable,
  output logic            crystal_mode_select,
  output logic            amplitude_control_enable,
  output logic            bias_double_enable,
  output logic            rtc_timebase_clock,
  output logic            stuck_clock_event,
  output logic            alarm_event
);

  // ---------------------------------------------------------------
  // reset release and input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [1:0] tb_sync;
  logic [1:0] bk_sync;
  logic       tb_prev;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  assign rst_n = rst_sync[1];
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      tb_sync <= 2'b00;
      bk_sync <= 2'b00;
      tb_prev <= 1'b0;
    end
    else
    begin
      tb_sync <= {tb_sync[0], timebase_in};
      bk_sync <= {bk_sync[0], backup_supply_in};
      tb_prev <= tb_sync[1];
    end
  logic tb_rise;
  logic tb_edge;
  assign tb_rise = tb_sync[1] & ~tb_prev;
  assign tb_edge = tb_sync[1] ^ tb_prev;
  // ---------------------------------------------------------------
  // registers and helpers
  // ---------------------------------------------------------------
  logic [7:0]           ctrl;
  logic [7:0]           osc;
  logic [7:0]           snap [6];
  logic [7:0]           alarm_flag [6];
  rtco_pkg::rtco_count_t timer;
  rtco_pkg::rtco_acc_t  acc;
  logic [31:0]          stuck_cnt;
  logic [31:0]          valid_cnt;
  logic                 osc_ok;
  logic                 stuck_hit;

  function automatic logic is_auto(input logic [3:0] a);
    is_auto = (a <= `RTCO_ADDR_SNAP_LAST) ||
              (a >= `RTCO_ADDR_ALARM_FLAG_FIRST && a <= `RTCO_ADDR_ALARM_FLAG_LAST);
  endfunction
  function automatic logic [2:0] byte_idx(input logic [3:0] a);
    byte_idx = a[3] ? 3'(a - `RTCO_ADDR_ALARM_FLAG_FIRST) : a[2:0];
  endfunction
  function automatic rtco_pkg::rtco_count_t pack47(input logic [7:0] b [6]);
    pack47 = {b[5], b[4], b[3], b[2], b[1], b[0][7:1]};
  endfunction
  rtco_pkg::rtco_count_t alarm_target;
  assign alarm_target = pack47(alarm_flag);
  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  always_comb
    if (data_wr)
      acc = rtco_pkg::RTCO_ACC_WRITE;
    else if (data_rd)
      acc = rtco_pkg::RTCO_ACC_READ;
    else
      acc = rtco_pkg::RTCO_ACC_IDLE;
  // ---------------------------------------------------------------
  // internal address field
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      internal_address_field <= 4'h0;
    else if (addr_wr)
      internal_address_field <= addr_wdata;
    else if (acc != rtco_pkg::RTCO_ACC_IDLE &&
             is_auto(internal_address_field))
      internal_address_field <= internal_address_field + 4'h1;
  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      indirect_data_port <= 8'h00;
    else if (acc == rtco_pkg::RTCO_ACC_READ)
      unique case (1'b1)
        internal_address_field == `RTCO_ADDR_CTRL:
          indirect_data_port <= ctrl;
        internal_address_field == `RTCO_ADDR_OSC:
          indirect_data_port <= osc;
        internal_address_field <= `RTCO_ADDR_SNAP_LAST:
          indirect_data_port <= snap[byte_idx(internal_address_field)];
        internal_address_field >= `RTCO_ADDR_ALARM_FLAG_FIRST &&
        internal_address_field <= `RTCO_ADDR_ALARM_FLAG_LAST:
          indirect_data_port <= alarm_flag[byte_idx(internal_address_field)];
        default:
          indirect_data_port <= 8'h00;
      endcase

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic ctl_wr;
  logic osc_wr;
  logic alarm_hit;
  assign ctl_wr = data_wr && internal_address_field == `RTCO_ADDR_CTRL;
  assign osc_wr = data_wr && internal_address_field == `RTCO_ADDR_OSC;
  assign alarm_hit = ctrl[`RTCO_CTL_AEN] && timer >= alarm_target;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ctrl <= `RTCO_CTRL_RESET;
    else
    begin
      if (ctl_wr)
        ctrl <= data_wdata;
      else
      begin
        ctrl[`RTCO_CTL_LOAD] <= 1'b0;
        ctrl[`RTCO_CTL_SNAP] <= 1'b0;
      end
      if (stuck_hit)
        ctrl[`RTCO_CTL_FAIL] <= 1'b1;
      if (alarm_hit)
        ctrl[`RTCO_CTL_ALARM_FLAG] <= 1'b1;
    end

  // ---------------------------------------------------------------
  // oscillator control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      osc <= `RTCO_OSC_RESET;
    else
    begin
      if (osc_wr)
        osc[7:5] <= data_wdata[7:5];
      osc[`RTCO_OSC_VALID] <= osc_ok && ctrl[`RTCO_CTL_POWER];
      osc[3:1] <= 3'b000;
      osc[`RTCO_OSC_BACK] <= bk_sync[1];
    end

  // ---------------------------------------------------------------
  // oscillator valid qualifier
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      valid_cnt <= 32'h0;
      osc_ok    <= 1'b0;
    end
    else if (!ctrl[`RTCO_CTL_POWER])
    begin
      valid_cnt <= 32'h0;
      osc_ok    <= 1'b0;
    end
    else if (!osc[`RTCO_OSC_XTAL])
      osc_ok <= 1'b1;
    else if (tb_rise)
    begin
      if (valid_cnt >= 32'(VALID_CYC))
        osc_ok <= 1'b1;
      else
        valid_cnt <= valid_cnt + 32'h1;
    end

  // ---------------------------------------------------------------
  // stuck-clock detector
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      stuck_cnt <= 32'h0;
      stuck_hit <= 1'b0;
    end
    else if (!ctrl[`RTCO_CTL_DET] || tb_edge)
    begin
      stuck_cnt <= 32'h0;
      stuck_hit <= 1'b0;
    end
    else if (stuck_cnt == 32'(STUCK_CYC))
    begin
      stuck_cnt <= stuck_cnt + 32'h1;
      stuck_hit <= 1'b1;
    end
    else
    begin
      stuck_hit <= 1'b0;
      if (stuck_cnt <= 32'(STUCK_CYC))
        stuck_cnt <= stuck_cnt + 32'h1;
    end

  // ---------------------------------------------------------------
  // timer, snapshot and alarm bytes
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      timer <= '0;
    else if (ctrl[`RTCO_CTL_LOAD])
      timer <= pack47(snap);
    else if (ctrl[`RTCO_CTL_RUN] && tb_rise)
      timer <= timer + 47'h1;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      for (int i = 0; i < 6; i++)
      begin
        snap[i] <= `RTCO_BYTE_RESET;
        alarm_flag[i] <= `RTCO_BYTE_RESET;
      end
    else
    begin
      if (data_wr && internal_address_field <= `RTCO_ADDR_SNAP_LAST)
        snap[byte_idx(internal_address_field)] <= data_wdata;
      else if (ctrl[`RTCO_CTL_SNAP])
        {snap[5], snap[4], snap[3], snap[2], snap[1], snap[0]} <=
          {timer, 1'b0};
      if (data_wr && internal_address_field >= `RTCO_ADDR_ALARM_FLAG_FIRST &&
          internal_address_field <= `RTCO_ADDR_ALARM_FLAG_LAST)
        alarm_flag[byte_idx(internal_address_field)] <= data_wdata;
    end

  // ---------------------------------------------------------------
  // oscillator controls and event outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      osc_power_enable         <= 1'b0;
      crystal_mode_select      <= 1'b0;
      amplitude_control_enable <= 1'b0;
      bias_double_enable       <= 1'b0;
      rtc_timebase_clock       <= 1'b0;
      stuck_clock_event        <= 1'b0;
      alarm_event              <= 1'b0;
    end
    else
    begin
      osc_power_enable         <= ctrl[`RTCO_CTL_POWER];
      crystal_mode_select      <= osc[`RTCO_OSC_XTAL];
      amplitude_control_enable <= osc[`RTCO_OSC_AMP];
      bias_double_enable       <= osc[`RTCO_OSC_BIAS];
      rtc_timebase_clock       <= tb_sync[1] & ctrl[`RTCO_CTL_POWER];
      stuck_clock_event        <= stuck_hit;
      alarm_event              <= alarm_hit;
    end

endmodule
